// *** common/switch_strap_pkg.sv ***
// constants, field positions and state codes for the port strap/sideband block
// assumes a single 125 MHz core clock and an active-low fundamental reset
package switch_strap_pkg;

	localparam int NUM_PORTS      = 3;
	localparam int CLK_PERIOD_NS  = 8;
	// reference clock + pll settle window before leaving the L1 substate
	localparam int PLL_SETTLE_NS  = 1000;
	localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// cycles after reset release before straps are captured (synchroniser + margin)
	localparam int STRAP_SETTLE_CYC = 4;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_STRAP = 8'h00;
	localparam logic [7:0] OFF_PORT  = 8'h04;
	localparam logic [7:0] OFF_CTRL  = 8'h08;

	// strap status word
	localparam int STRAP_VC1     = 0;
	localparam int STRAP_POLDET  = 1;
	localparam int STRAP_MPS512  = 2;
	localparam int STRAP_SHCLK   = 3;
	localparam int STRAP_SLOT_LO = 4;
	localparam int STRAP_SBSEL   = 6;
	localparam int STRAP_VALID   = 7;
	// port status word
	localparam int PORT_PRES_LO  = 1;
	localparam int PORT_L1_LO    = 4;
	localparam int PORT_PLL_LO   = 8;
	localparam int PORT_REQ_LO   = 12;
	// control word: per-port forced clock request
	localparam int CTRL_FORCE_LO = 0;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// index of bits inside the synchronised strap vector
	localparam int SS_VC1    = 0;
	localparam int SS_POLDIS = 1;
	localparam int SS_PL512  = 2;
	localparam int SS_SHCLK  = 3;
	localparam int SS_SLOT   = 4;
	localparam int SS_SEL    = 6;
	localparam int SS_W      = 7;

	localparam logic [2:0] MPS_256 = 3'h1;
	localparam logic [2:0] MPS_512 = 3'h2;

	typedef enum logic [1:0] {
		CLK_OFF  = 2'b00,
		CLK_WAKE = 2'b01,
		CLK_ON   = 2'b10
	} clk_state_t;

endpackage

// *** logic/pin_sync.sv ***
// two-flop synchroniser for a vector of pin inputs
// assumes each bit is an independent slow level; no bus coherency is kept
`timescale 1ns/10ps
module pin_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule

// *** logic/clock_request_port.sv ***
// per-port reference clock / pll sequencer driven by a clock request level
// assumes req_seen is already synchronised to sys_clk
`timescale 1ns/10ps
module clock_request_port #(
	parameter int SETTLE_CYC = switch_strap_pkg::PLL_SETTLE_CYC
) (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic req_seen,
	output logic      refclk_en,
	output logic      pll_en,
	output logic      in_l1
);

	localparam int CNT_W = $clog2(SETTLE_CYC + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYC - 1);

	switch_strap_pkg::clk_state_t state_ff;
	switch_strap_pkg::clk_state_t nxt_state;
	logic [CNT_W-1:0]             cnt_ff;
	logic [CNT_W-1:0]             nxt_cnt;
	logic                         refclk_en_ff;
	logic                         pll_en_ff;
	logic                         in_l1_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		unique case (state_ff)
			switch_strap_pkg::CLK_OFF: begin
				if (req_seen) begin
					nxt_state = switch_strap_pkg::CLK_WAKE;
					nxt_cnt   = '0;
				end
			end
			switch_strap_pkg::CLK_WAKE: begin
				if (!req_seen) begin
					nxt_state = switch_strap_pkg::CLK_OFF;
				end else if (cnt_ff == LAST) begin
					nxt_state = switch_strap_pkg::CLK_ON;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			switch_strap_pkg::CLK_ON: begin
				if (!req_seen) begin
					nxt_state = switch_strap_pkg::CLK_OFF;
				end
			end
			default: nxt_state = switch_strap_pkg::CLK_OFF;
		endcase
	end

	// reset parks the port in L1
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff     <= switch_strap_pkg::CLK_OFF;
			cnt_ff       <= '0;
			refclk_en_ff <= 1'b0;
			pll_en_ff    <= 1'b0;
			in_l1_ff     <= 1'b1;
		end else begin
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			refclk_en_ff <= nxt_state != switch_strap_pkg::CLK_OFF;
			pll_en_ff    <= nxt_state != switch_strap_pkg::CLK_OFF;
			in_l1_ff     <= nxt_state != switch_strap_pkg::CLK_ON;
		end
	end

	assign refclk_en = refclk_en_ff;
	assign pll_en    = pll_en_ff;
	assign in_l1     = in_l1_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_release_clk_off: assert property (!req_seen |=> !refclk_en && !pll_en && in_l1)
		else $error("clocks still on after clock request released");
	a_request_clk_on: assert property (req_seen |=> refclk_en && pll_en)
		else $error("clocks not enabled after clock request");
	a_l1_exit_settled: assert property ($fell(in_l1) |-> cnt_ff == LAST && $past(req_seen))
		else $error("L1 exit before pll settle window elapsed");

endmodule

// *** logic/port_strap_config.sv ***
// strap decode and shared sideband pin control for a three-port switch
// assumes strap pins are static board levels, presence pins may change at any
// time, and core inputs port_clk_need/port_link_status are on sys_clk
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module port_strap_config #(
	parameter int SETTLE_CYC = switch_strap_pkg::PLL_SETTLE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        extra_vc_enable_strap,
	input  wire logic        rx_polarity_detect_disable,
	input  wire logic        large_payload_strap,
	input  wire logic [2:1]  slot_presence_n,
	input  wire logic        shared_refclk_strap,
	input  wire logic [2:1]  slot_implemented_strap,
	input  wire logic        sideband_function_select,
	input  wire logic [2:0]  clock_request_n_in,
	output logic      [2:0]  clock_request_n_out,
	output logic      [2:0]  clock_request_n_oe,
	input  wire logic [2:0]  port_clk_need,
	input  wire logic [2:0]  port_link_status,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             vc1_enable,
	output logic             vc0_owns_vc1_buffers,
	output logic             rx_polarity_detect_enable,
	output logic      [2:0]  max_payload_cap,
	output logic             shared_refclk,
	output logic      [2:1]  slot_connected,
	output logic      [2:1]  device_present,
	output logic             straps_valid,
	output logic      [2:0]  refclk_enable,
	output logic      [2:0]  pll_enable,
	output logic      [2:0]  l1_substate
);

	localparam int SC_W = $clog2(switch_strap_pkg::STRAP_SETTLE_CYC + 1);
	localparam logic [SC_W-1:0] SC_LAST = SC_W'(switch_strap_pkg::STRAP_SETTLE_CYC - 1);

	function automatic logic [2:0] mps_code(input logic big);
		mps_code = big ? switch_strap_pkg::MPS_512 : switch_strap_pkg::MPS_256;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [switch_strap_pkg::SS_W-1:0] strap_pins;
	logic [switch_strap_pkg::SS_W-1:0] strap_sync;
	logic [2:1]                        pres_sync_n;
	logic [2:0]                        creq_sync_n;

	assign strap_pins = {
		sideband_function_select,
		slot_implemented_strap,
		shared_refclk_strap,
		large_payload_strap,
		rx_polarity_detect_disable,
		extra_vc_enable_strap
	};

	// undriven straps are pulled low on the board, so low is the safe reset value
	pin_sync #(
		.W       (switch_strap_pkg::SS_W),
		.RST_VAL ('0)
	) u_strap_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.d       (strap_pins),
		.q       (strap_sync)
	);

	pin_sync #(
		.W       (2),
		.RST_VAL (2'h3)
	) u_pres_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.d       (slot_presence_n),
		.q       (pres_sync_n)
	);

	pin_sync #(
		.W       (3),
		.RST_VAL (3'h7)
	) u_creq_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.d       (clock_request_n_in),
		.q       (creq_sync_n)
	);

	////////////////////////////////////////////////////////////////////////////
	// strap capture after reset release

	logic [SC_W-1:0] settle_cnt_ff;
	logic            valid_ff;
	logic            capture_now;
	logic            vc1_ff;
	logic            vc0_owns_ff;
	logic            poldet_ff;
	logic [2:0]      mps_ff;
	logic            shclk_ff;
	logic [2:1]      slot_ff;
	logic            sel_ff;

	// async reset only loads constants; pins are caught a few clocks after release
	assign capture_now = !valid_ff && (settle_cnt_ff == SC_LAST);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			settle_cnt_ff <= '0;
			valid_ff      <= 1'b0;
		end else if (!valid_ff) begin
			settle_cnt_ff <= settle_cnt_ff + 1'b1;
			valid_ff      <= capture_now;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			vc1_ff      <= 1'b0;
			vc0_owns_ff <= 1'b1;
			poldet_ff   <= 1'b1;
			mps_ff      <= switch_strap_pkg::MPS_256;
			shclk_ff    <= 1'b0;
			slot_ff     <= 2'h0;
			sel_ff      <= 1'b0;
		end else if (capture_now) begin
			vc1_ff      <= strap_sync[switch_strap_pkg::SS_VC1];
			vc0_owns_ff <= !strap_sync[switch_strap_pkg::SS_VC1];
			poldet_ff   <= !strap_sync[switch_strap_pkg::SS_POLDIS];
			mps_ff      <= mps_code(strap_sync[switch_strap_pkg::SS_PL512]);
			shclk_ff    <= strap_sync[switch_strap_pkg::SS_SHCLK];
			slot_ff     <= strap_sync[switch_strap_pkg::SS_SLOT +: 2];
			sel_ff      <= strap_sync[switch_strap_pkg::SS_SEL];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// live presence

	logic [2:1] present_ff;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			present_ff <= 2'h0;
		end else begin
			present_ff <= ~pres_sync_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared sideband pins

	logic [2:0] force_req_ff;
	logic [2:0] own_req;
	logic [2:0] req_seen;
	logic [2:0] nxt_cr_out;
	logic [2:0] nxt_cr_oe;
	logic [2:0] cr_out_ff;
	logic [2:0] cr_oe_ff;
	logic       mode_clkreq;
	logic       mode_status;

	// pins stay released until the select strap is known
	assign mode_clkreq = valid_ff && !sel_ff;
	assign mode_status = valid_ff && sel_ff;
	assign own_req     = port_clk_need | force_req_ff;

	assign nxt_cr_oe  = mode_status ? 3'h7 : (mode_clkreq ? own_req : 3'h0);
	assign nxt_cr_out = mode_status ? port_link_status : 3'h0;

	// pin level is wired-or of all requesters; status mode keeps clocks up
	assign req_seen = mode_clkreq ? ~creq_sync_n : (mode_status ? 3'h7 : 3'h0);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cr_out_ff <= 3'h0;
			cr_oe_ff  <= 3'h0;
		end else begin
			cr_out_ff <= nxt_cr_out;
			cr_oe_ff  <= nxt_cr_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-port clock sequencers

	logic [2:0] refclk_en_w;
	logic [2:0] pll_en_w;
	logic [2:0] in_l1_w;

	for (genvar p = 0; p < switch_strap_pkg::NUM_PORTS; p++) begin : g_port
		clock_request_port #(
			.SETTLE_CYC (SETTLE_CYC)
		) u_creq (
			.sys_clk   (sys_clk),
			.arst_n    (arst_n),
			.req_seen  (req_seen[p]),
			.refclk_en (refclk_en_w[p]),
			.pll_en    (pll_en_w[p]),
			.in_l1     (in_l1_w[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// register port

	logic        hit_strap;
	logic        hit_port;
	logic        hit_ctrl;
	logic [31:0] strap_word;
	logic [31:0] port_word;
	logic [31:0] ctrl_word;
	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;

	assign hit_strap = reg_addr == switch_strap_pkg::OFF_STRAP;
	assign hit_port  = reg_addr == switch_strap_pkg::OFF_PORT;
	assign hit_ctrl  = reg_addr == switch_strap_pkg::OFF_CTRL;

	// layouts follow the field positions in the package
	assign strap_word = {24'h0, valid_ff, sel_ff, slot_ff, shclk_ff,
		mps_ff == switch_strap_pkg::MPS_512, poldet_ff, vc1_ff};
	assign port_word  = {17'h0, ~creq_sync_n, 1'b0, pll_en_w, 1'b0, in_l1_w,
		1'b0, present_ff, 1'b0};
	assign ctrl_word  = {29'h0, force_req_ff};

	// unmapped reads return zero; data stand only in the cycle after the strobe
	assign nxt_rdata = !reg_rd ? 32'h0 :
		hit_strap ? strap_word :
		hit_port  ? port_word  :
		hit_ctrl  ? ctrl_word  : 32'h0;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 32'h0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// software can hold a port's clock on, e.g. for debug with the core idle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			force_req_ff <= switch_strap_pkg::CTRL_RST;
		end else if (reg_wr && hit_ctrl) begin
			force_req_ff <= reg_wdata[switch_strap_pkg::CTRL_FORCE_LO +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata                 = rdata_ff;
	assign vc1_enable                = vc1_ff;
	assign vc0_owns_vc1_buffers      = vc0_owns_ff;
	assign rx_polarity_detect_enable = poldet_ff;
	assign max_payload_cap           = mps_ff;
	assign shared_refclk             = shclk_ff;
	assign slot_connected            = slot_ff;
	assign device_present            = present_ff;
	assign straps_valid              = valid_ff;
	assign clock_request_n_out       = cr_out_ff;
	assign clock_request_n_oe        = cr_oe_ff;
	assign refclk_enable             = refclk_en_w;
	assign pll_enable                = pll_en_w;
	assign l1_substate               = in_l1_w;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_vc1_exclusive: assert property (vc1_enable != vc0_owns_vc1_buffers)
		else $error("vc1 enable and vc0 buffer ownership disagree");
	a_vc1_capture: assert property (capture_now |=>
		vc0_owns_vc1_buffers == !$past(strap_sync[switch_strap_pkg::SS_VC1]))
		else $error("vc1 strap not reflected in buffer ownership");
	a_poldet_capture: assert property (capture_now |=>
		rx_polarity_detect_enable == !$past(strap_sync[switch_strap_pkg::SS_POLDIS]))
		else $error("polarity detect enable not inverse of strap");
	a_mps_capture: assert property (capture_now |=>
		max_payload_cap == mps_code($past(strap_sync[switch_strap_pkg::SS_PL512])))
		else $error("payload capability code wrong");
	a_presence_map: assert property ($stable(slot_presence_n) [*3] |=>
		device_present == ~$past(slot_presence_n))
		else $error("presence does not follow low-active pin");
	a_slot_capture: assert property (capture_now |=>
		slot_connected == $past(strap_sync[switch_strap_pkg::SS_SLOT +: 2]))
		else $error("slot implemented strap not captured");
	a_clkreq_drive: assert property (straps_valid && !sel_ff |=>
		clock_request_n_out == 3'h0 && clock_request_n_oe == $past(own_req))
		else $error("clock request pins not open-drain low requests");
	a_status_drive: assert property (straps_valid && sel_ff |=>
		clock_request_n_oe == 3'h7 && clock_request_n_out == $past(port_link_status))
		else $error("status pins not driving port status");
	a_straps_held: assert property (straps_valid |=> straps_valid &&
		$stable({vc1_enable, max_payload_cap, shared_refclk, slot_connected, sel_ff}))
		else $error("captured straps changed before reset");
	a_capture_time: assert property ($rose(straps_valid) |->
		$past(settle_cnt_ff) == SC_LAST)
		else $error("straps captured at wrong time");
	a_unmapped_zero: assert property (reg_rd && !hit_strap && !hit_port && !hit_ctrl |=>
		reg_rdata == 32'h0)
		else $error("unmapped read returned nonzero");

	c_clkreq_mode: cover property (straps_valid && !sel_ff && refclk_enable[1]);
	c_status_mode: cover property (straps_valid && sel_ff && clock_request_n_out != 3'h0);
	c_l1_exit: cover property ($fell(l1_substate[0]));
	c_l1_enter: cover property ($rose(l1_substate[2]) && straps_valid);

endmodule

// *** tb/board_sideband_model.sv ***
// board side of the shared sideband pins: pull-ups and far-end clock requests
// assumes the device pins arrive split into output value and output enable
`timescale 1ns/10ps
module board_sideband_model (
	input  wire logic [2:0] clock_request_n_out,
	input  wire logic [2:0] clock_request_n_oe,
	input  wire logic [2:0] board_req,
	output logic      [2:0] pin_level
);
	////////////////////////////////////////////////////////////////////////////////
	wire [2:0] dev_low = clock_request_n_oe & ~clock_request_n_out;
	// far end asserts or releases request
	// released wire floats to the pull-up, never keeps the last driven value
	assign pin_level = ~(dev_low | board_req);
endmodule

// *** tb/tb_port_strap_config.sv ***
// self-checking bench for the strap decode and shared sideband block
// assumes the board model resolves the open-drain sideband wires
`timescale 1ns/10ps
module tb_port_strap_config;
	logic        sys_clk   = 1'b0;
	logic        arst_n    = 1'b0;
	logic [6:0]  sv        = 7'h00;
	logic [2:1]  pres_n    = 2'h3;
	logic [2:0]  board_req = 3'h0;
	logic [2:0]  clk_need  = 3'h0;
	logic [2:0]  link_st   = 3'h0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        rd_seen   = 1'b0;
	logic [31:0] reg_rdata;
	logic [2:0]  cr_out, cr_oe, pin_level, mps, refclk_en, pll_en, l1;
	logic        vc1, vc0own, rxen, shclk, valid;
	logic [2:1]  slot_conn, dev_pres;
	logic [31:0] exp_q[$];
	logic [6:0]  s;
	int          miscompares = 0;
	int          comparisons = 0;
	wire  [31:0] lvl_now = {22'h0, vc1, vc0own, rxen, mps, shclk, slot_conn, valid};

	always #4 sys_clk = ~sys_clk;

	port_strap_config #(.SETTLE_CYC(4)) port_strap_config_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .extra_vc_enable_strap(sv[0]),
		.rx_polarity_detect_disable(sv[1]), .large_payload_strap(sv[2]),
		.slot_presence_n(pres_n), .shared_refclk_strap(sv[3]),
		.slot_implemented_strap(sv[5:4]), .sideband_function_select(sv[6]),
		.clock_request_n_in(pin_level), .clock_request_n_out(cr_out),
		.clock_request_n_oe(cr_oe), .port_clk_need(clk_need), .port_link_status(link_st),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .vc1_enable(vc1), .vc0_owns_vc1_buffers(vc0own),
		.rx_polarity_detect_enable(rxen), .max_payload_cap(mps), .shared_refclk(shclk),
		.slot_connected(slot_conn), .device_present(dev_pres), .straps_valid(valid),
		.refclk_enable(refclk_en), .pll_enable(pll_en), .l1_substate(l1)
	);

	board_sideband_model board_sideband_model_inst (
		.clock_request_n_out(cr_out), .clock_request_n_oe(cr_oe),
		.board_req(board_req), .pin_level(pin_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic compare_level(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: level %h expected %h", $time, got, exp);
		end
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen) begin
			compare_word(reg_rdata, exp_q.pop_front());
		end
		rd_seen <= reg_rd;
	end

	function automatic logic [31:0] lvl_exp(input logic [6:0] t);
		return {22'h0, t[0], ~t[0], ~t[1],
			t[2] ? switch_strap_pkg::MPS_512 : switch_strap_pkg::MPS_256, t[3], t[5:4], 1'b1};
	endfunction

	function automatic logic [31:0] strap_word(input logic [6:0] t);
		return {24'h0, 1'b1, t[6], t[5:4], t[3], t[2], ~t[1], t[0]};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic do_reset(input logic [6:0] t);
		@(posedge sys_clk);
		sv <= t;
		arst_n <= 1'b0;
		cyc(3);
		compare_level(lvl_now, {22'h0, 3'b011, switch_strap_pkg::MPS_256, 4'h0});
		compare_level({26'h0, l1, cr_oe}, {26'h0, 3'h7, 3'h0});
		@(posedge sys_clk);
		arst_n <= 1'b1;
		cyc(8);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 8);
		miscompares++;
		wrap_up();
	end

	initial begin
		void'($urandom(51042));
		// boundary patterns first, then random strap sets
		for (int i = 0; i < 6; i++) begin
			s = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
			do_reset(s);
			compare_level(lvl_now, lvl_exp(s));
			reg_read(8'h00, strap_word(s));
			@(posedge sys_clk);
			sv <= ~s;
			cyc(8);
			compare_level(lvl_now, lvl_exp(s));
		end
		$display("strap capture test done");

		do_reset(7'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			pres_n <= 2'($urandom);
			cyc(4);
			compare_level({30'h0, dev_pres}, {30'h0, ~pres_n});
			reg_read(8'h04, {25'h0, 3'h7, 1'b0, ~pres_n, 1'b0});
		end
		$display("presence test done");

		@(posedge sys_clk);
		board_req <= 3'b100;
		cyc(4);
		compare_level({29'h0, refclk_en[2], pll_en[2], l1[2]}, 32'h7);
		cyc(8);
		compare_level({26'h0, refclk_en, l1}, {26'h0, 3'b100, 3'b011});
		reg_read(8'h04, {17'h0, 3'h4, 1'b0, 3'h4, 1'b0, 3'h3, 1'b0, ~pres_n, 1'b0});
		@(posedge sys_clk);
		board_req <= 3'b000;
		cyc(4);
		compare_level({26'h0, refclk_en | pll_en, l1}, {26'h0, 3'h0, 3'h7});
		@(posedge sys_clk);
		clk_need <= 3'b010;
		cyc(2);
		compare_level({26'h0, cr_oe, cr_out}, {26'h0, 3'b010, 3'b000});
		cyc(10);
		compare_level({26'h0, pll_en, l1}, {26'h0, 3'b010, 3'b101});
		@(posedge sys_clk);
		clk_need <= 3'b000;
		reg_write(8'h08, 32'h1);
		reg_read(8'h08, 32'h1);
		cyc(2);
		compare_level({29'h0, cr_oe}, 32'h1);
		reg_write(8'h08, 32'h0);
		reg_write(8'h00, 32'hFFFF_FFFF);
		reg_read(8'h00, strap_word(7'h00));
		reg_read(8'h0C, 32'h0);
		cyc(6);
		$display("clock request test done");

		do_reset(7'h40);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			link_st <= 3'($urandom);
			cyc(2);
			compare_level({23'h0, pin_level, cr_oe, cr_out},
				{23'h0, link_st, 3'h7, link_st});
		end
		$display("status mode test done");
		cyc(4);
		wrap_up();
	end
endmodule
